// *** src/lcd_pds_pkg.sv ***
// Shared constants and types for the palette, dithering and shifter stage.
// Assumes one core clock domain and a plain address/strobe register port.
package lcd_pds_pkg;

  // Register port geometry and map (byte addresses)
  localparam int          ADDR_W    = 12;
  localparam int          DATA_W    = 32;
  localparam logic [11:0] CFG_OFF   = 12'h000;
  localparam logic [11:0] STAT_OFF  = 12'h004;
  localparam logic [11:0] PAT_BASE  = 12'h020;
  localparam logic [11:0] PAT_LAST  = 12'h03c;
  localparam logic [11:0] LUT_BASE  = 12'h400;
  localparam logic [11:0] LUT_LAST  = 12'h7fc;

  // Interface configuration register fields
  localparam int CFG_TYPE_LSB = 0;
  localparam int CFG_SCAN_BIT = 2;
  localparam int CFG_WID_LSB  = 3;
  localparam int CFG_BPP_LSB  = 5;
  localparam int CFG_W        = 8;
  localparam logic [7:0] CFG_RST = 8'h00;

  // Palette entry layout: intensity, blue, green, red
  localparam int ENT_W     = 16;
  localparam int LUT_DEPTH = 256;
  localparam int LUT_AW    = 8;
  localparam int ENT_I     = 15;
  localparam int ENT_B_LSB = 10;
  localparam int ENT_G_LSB = 5;
  localparam int ENT_R_LSB = 0;
  localparam int COMP_W    = 5;

  // TFT panel lane bases (one byte lane per colour)
  localparam int TFT_R_LSB = 0;
  localparam int TFT_G_LSB = 8;
  localparam int TFT_B_LSB = 16;
  localparam int TFT_I_POS = 2;
  localparam int BUS_W     = 24;

  // Frame rate control pattern registers
  localparam int          NUM_PAT = 8;
  localparam int          PAT_W   = 28;
  localparam logic [27:0] PAT_RST = 28'h0000000;
  localparam logic [3:0]  LVL_ON  = 4'hf;
  localparam logic [3:0]  LVL_OFF = 4'h0;

  typedef enum logic [1:0] {DISP_TFT, DISP_MONO, DISP_COLOR} disp_t;
  typedef enum logic [2:0] {BPP_1, BPP_2, BPP_4, BPP_8, BPP_16, BPP_24} bpp_t;
  typedef enum logic [1:0] {IF_4, IF_8, IF_16} ifw_t;
  typedef enum logic [2:0] {PAT_67, PAT_45, PAT_34, PAT_57,
                            PAT_23, PAT_35, PAT_47, PAT_12} pat_t;

  // Number of 4-bit patterns held by each pattern register
  function automatic logic [2:0] pat_len(input logic [2:0] idx);
    case (pat_t'(idx))
      PAT_45, PAT_35: pat_len = 3'h5;
      PAT_34:         pat_len = 3'h4;
      PAT_23:         pat_len = 3'h3;
      PAT_12:         pat_len = 3'h2;
      default:        pat_len = 3'h7;
    endcase
  endfunction : pat_len

endpackage : lcd_pds_pkg

// *** src/lut_ram.sv ***
// Colour lookup table storage, 256 entries of 16 bits.
// Host port reads combinationally; pixel port read data is registered.
`timescale 1ns/10ps
`default_nettype none
module lut_ram
  import lcd_pds_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_rstn,
  input  wire logic [LUT_AW-1:0] i_haddr,
  input  wire logic              i_hwe,
  input  wire logic [ENT_W-1:0]  i_hwdata,
  output logic      [ENT_W-1:0]  o_hrdata,
  input  wire logic [LUT_AW-1:0] i_paddr,
  output logic      [ENT_W-1:0]  o_pdata
);

  logic [ENT_W-1:0] mem [LUT_DEPTH];

  // Host writes; contents are free after reset
  always_ff @(posedge i_mclk) begin
    if (i_hwe) begin
      mem[i_haddr] <= i_hwdata;
    end
  end

  // Pixel lookup, one cycle of latency
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pdata <= '0;
    end else begin
      o_pdata <= mem[i_paddr];
    end
  end

  assign o_hrdata = mem[i_haddr];

endmodule : lut_ram
`default_nettype wire

// *** src/frc_dither.sv ***
// One frame rate control decision for one 4-bit gray level.
// Purely combinational; the frame phases come from the caller.
`timescale 1ns/10ps
`default_nettype none
module frc_dither
  import lcd_pds_pkg::*;
(
  input  wire logic [3:0]               i_level,
  input  wire logic [1:0]               i_bitpos,
  input  wire logic [NUM_PAT*PAT_W-1:0] i_pat,
  input  wire logic [NUM_PAT*3-1:0]     i_phase,
  output logic                          o_on
);

  logic [2:0]       sel;
  logic             inv;
  logic [PAT_W-1:0] reg_v;
  logic [2:0]       k;
  logic [4:0]       sh;
  logic [3:0]       nib;

  // Level to pattern register; lower half uses inverted patterns
  always_comb begin
    sel = 3'(PAT_67);
    inv = 1'b0;
    case (i_level)
      4'he: sel = 3'(PAT_67);
      4'hd: sel = 3'(PAT_45);
      4'hc: sel = 3'(PAT_34);
      4'hb: sel = 3'(PAT_57);
      4'ha: sel = 3'(PAT_23);
      4'h9: sel = 3'(PAT_35);
      4'h8: sel = 3'(PAT_47);
      4'h7: begin sel = 3'(PAT_12); inv = 1'b1; end // [R11]
      4'h6: begin sel = 3'(PAT_47); inv = 1'b1; end
      4'h5: begin sel = 3'(PAT_35); inv = 1'b1; end
      4'h4: begin sel = 3'(PAT_23); inv = 1'b1; end
      4'h3: begin sel = 3'(PAT_34); inv = 1'b1; end
      4'h2: begin sel = 3'(PAT_45); inv = 1'b1; end
      4'h1: begin sel = 3'(PAT_67); inv = 1'b1; end
      default: ;
    endcase
  end

  // First pattern sits in the top nibble of the used width
  always_comb begin
    reg_v = i_pat[sel*PAT_W +: PAT_W];
    k     = i_phase[sel*3 +: 3];
    sh    = {pat_len(sel) - 3'h1 - k, 2'b00}; // [R14]
    nib   = 4'(reg_v >> sh);
    if (i_level == LVL_ON) begin
      o_on = 1'b1; // [R12]
    end else if (i_level == LVL_OFF) begin
      o_on = 1'b0; // [R12]
    end else begin
      o_on = nib[i_bitpos] ^ inv; // [R13] [R10]
    end
  end

endmodule : frc_dither
`default_nettype wire

// *** src/lcd_palette_dither_shifter.sv ***
// Palette lookup, frame rate control dithering and panel data packing.
// Assumes pixels arrive from a serializer with line and frame pulses,
// and a register master that never needs wait states.
//
// Operation
// R1: palettized pixels index the lookup table
// R2: bypass palette for largest pixel size per type
// R3: host reads/writes table, low 16 bits
// R4: table holds 256 sixteen-bit entries
// R5: entry is intensity, blue, green, red
// R6: mono uses upper four red bits
// R7: colour uses upper four bits each
// R8: TFT uses five bits plus intensity
// R9: TFT palettized unused lines held zero
// R10: STN shades by frame rate control
// R11: levels map to pattern registers or inverses
// R12: levels 15 and 0 fixed on/off
// R13: coordinate 4n+m takes pattern bit 3-m
// R14: pattern advances per frame and wraps
// R15: colour sub-pixels take successive bit positions
// R16: sub-pixels packed red first, MSB down
// R17: dual scan halves behave like single scan
// R18: one pixel or three sub-pixels per step
// R19: display type selects TFT, mono, colour
// R20: scan selects single or dual, TFT single
// R21: STN widths 4 single, 8, 16 dual
// R22: frame counter advances per frame, resets zero
`timescale 1ns/10ps
`default_nettype none
module lcd_palette_dither_shifter
  import lcd_pds_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_rstn,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  input  wire logic              i_frame_start,
  input  wire logic              i_line_start,
  input  wire logic              i_pix_valid,
  input  wire logic [BUS_W-1:0]  i_pix_data,
  input  wire logic              i_pix_half,
  output logic      [BUS_W-1:0]  o_panel_data_bus,
  output logic                   o_panel_valid,
  output logic                   o_panel_half
);

  logic [CFG_W-1:0]  cfg_q;
  logic [PAT_W-1:0]  pat_q   [NUM_PAT];
  logic [2:0]        phase_q [NUM_PAT];
  logic              s1_valid_q;
  logic [BUS_W-1:0]  s1_raw_q;
  logic              s1_half_q;
  logic              s1_pal_q;
  logic [15:0]       acc_q [2];
  logic [4:0]        cnt_q [2];
  logic [1:0]        sub_q [2];

  // Decoded configuration
  disp_t             dtype;
  bpp_t              bpp;
  logic              dual;
  logic [4:0]        half_w;
  logic              use_pal;

  // Decode helpers, used by the configuration decode and the pixel table lookup
  function automatic disp_t dec_type(input logic [1:0] v);
    case (v)
      2'h1:    dec_type = DISP_MONO;
      2'h2:    dec_type = DISP_COLOR;
      default: dec_type = DISP_TFT;
    endcase
  endfunction : dec_type

  function automatic logic pal_needed(input disp_t t, input bpp_t b);
    case (t)
      DISP_MONO: pal_needed = (b == BPP_1) || (b == BPP_2);
      default:   pal_needed = (b != BPP_16) && (b != BPP_24);
    endcase
  endfunction : pal_needed

  function automatic logic [7:0] idx_mask(input bpp_t b);
    case (b)
      BPP_1:   idx_mask = 8'h01;
      BPP_2:   idx_mask = 8'h03;
      BPP_4:   idx_mask = 8'h0f;
      default: idx_mask = 8'hff;
    endcase
  endfunction : idx_mask

  // Type, scan and width decode; illegal combinations fall to 8 lines
  always_comb begin
    dtype   = dec_type(cfg_q[CFG_TYPE_LSB +: 2]); // [R19]
    bpp     = bpp_t'(cfg_q[CFG_BPP_LSB +: 3]);
    dual    = cfg_q[CFG_SCAN_BIT] && (dtype != DISP_TFT); // [R20]
    use_pal = pal_needed(dtype, bpp); // [R2]
    case (ifw_t'(cfg_q[CFG_WID_LSB +: 2]))
      IF_4:    half_w = dual ? 5'h4 : 5'h4; // [R21]
      IF_16:   half_w = dual ? 5'h8 : 5'h8;
      default: half_w = dual ? 5'h4 : 5'h8;
    endcase
  end

  // Register decode
  logic             hit_cfg;
  logic             hit_stat;
  logic             hit_pat;
  logic             hit_lut;
  logic [2:0]       pat_idx;
  logic [ENT_W-1:0] lut_hrdata;
  logic [ENT_W-1:0] lut_pdata;
  logic [23:0]      phase_flat;

  always_comb begin
    hit_cfg  = 1'b0;
    hit_stat = 1'b0;
    hit_pat  = 1'b0;
    hit_lut  = 1'b0;
    pat_idx  = i_addr[4:2];
    if (i_addr[1:0] != 2'h0) begin
      hit_cfg = 1'b0;
    end else if (i_addr == CFG_OFF) begin
      hit_cfg = 1'b1;
    end else if (i_addr == STAT_OFF) begin
      hit_stat = 1'b1;
    end else if (i_addr >= PAT_BASE && i_addr <= PAT_LAST) begin
      hit_pat = 1'b1;
    end else if (i_addr >= LUT_BASE && i_addr <= LUT_LAST) begin
      hit_lut = 1'b1;
    end
  end

  // Configuration register write
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_q <= CFG_RST;
    end else if (i_wr && hit_cfg) begin
      cfg_q <= i_wdata[CFG_W-1:0];
    end
  end

  // Pattern register writes
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < NUM_PAT; i++) begin
        pat_q[i] <= PAT_RST;
      end
    end else if (i_wr && hit_pat) begin
      pat_q[pat_idx] <= i_wdata[PAT_W-1:0];
    end
  end

  // Per-register frame phase; each wraps at its own pattern count
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < NUM_PAT; i++) begin
        phase_q[i] <= 3'h0; // [R22]
      end
    end else if (i_frame_start) begin
      for (int i = 0; i < NUM_PAT; i++) begin
        if (phase_q[i] == pat_len(3'(i)) - 3'h1) begin
          phase_q[i] <= 3'h0; // [R14]
        end else begin
          phase_q[i] <= phase_q[i] + 3'h1; // [R22]
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_PAT; i++) begin
      phase_flat[i*3 +: 3] = phase_q[i];
    end
  end

  // Read data, loaded in the cycle after the strobe and held until the next read
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      if (hit_cfg) begin
        o_rdata <= DATA_W'(cfg_q);
      end else if (hit_stat) begin
        o_rdata <= DATA_W'(phase_flat);
      end else if (hit_pat) begin
        o_rdata <= DATA_W'(pat_q[pat_idx]);
      end else if (hit_lut) begin
        o_rdata <= DATA_W'(lut_hrdata); // [R3]
      end else begin
        o_rdata <= '0;
      end
    end
  end

  // Lookup table; upper bus half is dropped on write
  lut_ram u_lut (
    .i_mclk   (i_mclk),
    .i_rstn   (i_rstn),
    .i_haddr  (i_addr[9:2]),
    .i_hwe    (i_wr && hit_lut), // [R3]
    .i_hwdata (i_wdata[ENT_W-1:0]),
    .o_hrdata (lut_hrdata),
    .i_paddr  (i_pix_data[LUT_AW-1:0] & idx_mask(bpp)), // [R1] [R4]
    .o_pdata  (lut_pdata)
  );

  // Stage one: hold the pixel while the table is read
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_valid_q <= 1'b0;
      s1_raw_q   <= '0;
      s1_half_q  <= 1'b0;
      s1_pal_q   <= 1'b0;
    end else begin
      s1_valid_q <= i_pix_valid;
      s1_raw_q   <= i_pix_data;
      s1_half_q  <= i_pix_half && dual;
      s1_pal_q   <= use_pal;
    end
  end

  // Colour word and gray levels for this step
  logic [ENT_W-1:0] word;
  logic [3:0]       lv [3];
  logic [1:0]       pos [3];
  logic [2:0]       on;
  logic [NUM_PAT*PAT_W-1:0] pat_flat;

  always_comb begin
    word  = s1_pal_q ? lut_pdata : s1_raw_q[ENT_W-1:0]; // [R1] [R2] [R5]
    lv[0] = word[ENT_R_LSB+1 +: 4]; // [R6] [R7]
    lv[1] = word[ENT_G_LSB+1 +: 4]; // [R7]
    lv[2] = word[ENT_B_LSB+1 +: 4];
    if (dtype == DISP_MONO && !s1_pal_q) begin
      lv[0] = s1_raw_q[3:0];
    end
    for (int j = 0; j < 3; j++) begin
      pos[j] = ~(sub_q[s1_half_q] + 2'(j)); // [R13] [R15]
    end
    for (int i = 0; i < NUM_PAT; i++) begin
      pat_flat[i*PAT_W +: PAT_W] = pat_q[i];
    end
  end

  // One dithering decision per sub-pixel
  for (genvar g = 0; g < 3; g++) begin : g_frc
    frc_dither u_frc (
      .i_level  (lv[g]),
      .i_bitpos (pos[g]),
      .i_pat    (pat_flat),
      .i_phase  (phase_flat),
      .o_on     (on[g])
    );
  end

  // Packing arithmetic for the half in stage one
  logic        mono;
  logic [1:0]  nbits;
  logic [2:0]  push;
  logic [15:0] acc_d;
  logic [4:0]  cnt_d;
  logic        emit;
  logic [7:0]  out_w;
  logic [7:0]  wmask;
  logic [4:0]  lane;

  always_comb begin
    mono  = (dtype == DISP_MONO);
    nbits = mono ? 2'h1 : 2'h3; // [R18]
    push  = mono ? {2'h0, on[0]} : {on[0], on[1], on[2]}; // [R16]
    acc_d = (acc_q[s1_half_q] << nbits) | 16'(push);
    cnt_d = cnt_q[s1_half_q] + 5'(nbits);
    emit  = (cnt_d >= half_w);
    out_w = 8'(acc_d >> (cnt_d - half_w)); // [R16]
    wmask = (half_w == 5'h4) ? 8'h0f : 8'hff;
    lane  = (dual && !s1_half_q) ? half_w : 5'h0; // [R17]
  end

  // Shift state per half; a line start restarts coordinates
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int h = 0; h < 2; h++) begin
        acc_q[h] <= '0;
        cnt_q[h] <= '0;
        sub_q[h] <= '0;
      end
    end else if (i_line_start) begin
      for (int h = 0; h < 2; h++) begin
        acc_q[h] <= '0;
        cnt_q[h] <= '0;
        sub_q[h] <= '0;
      end
    end else if (s1_valid_q && dtype != DISP_TFT) begin
      acc_q[s1_half_q] <= acc_d;
      cnt_q[s1_half_q] <= emit ? cnt_d - half_w : cnt_d;
      sub_q[s1_half_q] <= sub_q[s1_half_q] + nbits; // [R15]
    end
  end

  // Panel bus: TFT per pixel, STN per filled word
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_panel_data_bus <= '0;
      o_panel_valid    <= 1'b0;
      o_panel_half     <= 1'b0;
    end else if (s1_valid_q && dtype == DISP_TFT) begin
      o_panel_valid <= 1'b1;
      o_panel_half  <= 1'b0;
      if (bpp == BPP_24) begin
        o_panel_data_bus <= s1_raw_q;
      end else begin
        o_panel_data_bus <= '0; // [R9]
        o_panel_data_bus[TFT_R_LSB+3 +: COMP_W] <= word[ENT_R_LSB +: COMP_W]; // [R8]
        o_panel_data_bus[TFT_G_LSB+3 +: COMP_W] <= word[ENT_G_LSB +: COMP_W];
        o_panel_data_bus[TFT_B_LSB+3 +: COMP_W] <= word[ENT_B_LSB +: COMP_W];
        o_panel_data_bus[TFT_R_LSB+TFT_I_POS]   <= word[ENT_I]; // [R8]
        o_panel_data_bus[TFT_G_LSB+TFT_I_POS]   <= word[ENT_I];
        o_panel_data_bus[TFT_B_LSB+TFT_I_POS]   <= word[ENT_I];
      end
    end else if (s1_valid_q && emit && !i_line_start) begin
      o_panel_valid <= 1'b1;
      o_panel_half  <= s1_half_q;
      // Other half keeps its lines; single scan clears upper lines
      if (dual) begin
        o_panel_data_bus <= (o_panel_data_bus & ~(BUS_W'(wmask) << lane))
                            | (BUS_W'(out_w & wmask) << lane); // [R17]
      end else begin
        o_panel_data_bus <= BUS_W'(out_w & wmask); // [R16]
      end
    end else begin
      o_panel_valid <= 1'b0;
    end
  end

  // TFT palettized pixel leaves unused lines at zero
  a_tft_unused_zero: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [R9]
    (s1_valid_q && dtype == DISP_TFT && s1_pal_q)
    |=> (o_panel_data_bus[17:16] == 2'h0 && o_panel_data_bus[9:8] == 2'h0
         && o_panel_data_bus[1:0] == 2'h0))
    else $error("TFT unused lines not zero");

  // Intensity replicated on all three components
  a_tft_intensity: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [R8]
    (s1_valid_q && dtype == DISP_TFT && bpp != BPP_24)
    |=> (o_panel_data_bus[18] == $past(word[ENT_I])
         && o_panel_data_bus[10] == o_panel_data_bus[18]
         && o_panel_data_bus[2] == o_panel_data_bus[18]))
    else $error("intensity bit not on lines 18 10 2");

  // Full colour pixel passes straight through
  a_tft_bypass: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [R2]
    (s1_valid_q && dtype == DISP_TFT && bpp == BPP_24)
    |=> o_panel_data_bus == $past(s1_raw_q))
    else $error("24 bpp pixel altered");

  // Fixed levels ignore the patterns on mono pixels
  a_level_fixed: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [R12]
    (s1_valid_q && mono) |-> ((lv[0] != LVL_ON || on[0])
                              && (lv[0] != LVL_OFF || !on[0])))
    else $error("level 15 or 0 dithered");

  // Seven-pattern phase wraps after its last pattern
  a_phase_wrap: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [R14]
    (i_frame_start && phase_q[3'(PAT_67)] == 3'h6)
    |=> phase_q[3'(PAT_67)] == 3'h0)
    else $error("phase did not wrap");

  // Phase holds between frame starts, steps by one on them
  a_phase_step: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [R22]
    (phase_q[3'(PAT_45)] != 3'h4) |=> (phase_q[3'(PAT_45)]
      == $past(phase_q[3'(PAT_45)]) + 3'($past(i_frame_start))))
    else $error("frame phase stepped wrongly");

  // Palette reads show zeros in the upper half
  a_lut_upper_zero: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [R3]
    (i_rd && hit_lut) |=> o_rdata[31:16] == 16'h0000)
    else $error("palette read upper half not zero");

  // A filled word reaches the bus on the next edge
  a_pack_emit: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [R18]
    (s1_valid_q && dtype != DISP_TFT && emit && !i_line_start)
    |=> (o_panel_valid && o_panel_half == $past(s1_half_q)))
    else $error("packed word not emitted");

  // TFT never drives the second half
  a_tft_single: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [R20]
    (s1_valid_q && dtype == DISP_TFT) |=> !o_panel_half)
    else $error("TFT used dual scan");

endmodule : lcd_palette_dither_shifter
`default_nettype wire

// *** sim/panel_model.sv ***
// Panel column driver model: shift register that latches each bus word.
// Assumes one valid pulse per new word, sampled on the core clock.
`timescale 1ns/10ps
`default_nettype none
module panel_model (
  input wire logic        i_mclk,
  input wire logic        i_valid,
  input wire logic        i_half,
  input wire logic [23:0] i_data
);
  logic [24:0] got[$];

  // Latch a word only on its strobe; the bus may hold stale data between
  always @(posedge i_mclk) begin
    if (i_valid === 1'b1) got.push_back({i_half, i_data});
  end
endmodule : panel_model
`default_nettype wire

// *** sim/lcd_palette_dither_shifter_bench.sv ***
// Self-checking bench: register port, palette, dithering and packing.
// Assumes the panel model collects words; expected words come from a model here.
`timescale 1ns/10ps
`default_nettype none
module lcd_palette_dither_shifter_bench import lcd_pds_pkg::*;;
  logic              i_mclk, i_rstn, i_wr, i_rd, i_frame_start, i_line_start;
  logic              i_pix_valid, i_pix_half, o_panel_valid, o_panel_half;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata, o_rdata;
  logic [BUS_W-1:0]  i_pix_data, o_panel_data_bus;
  logic [24:0]       exp_q[$];
  int                lut[256], pats[8], f, s[2], acc[2], cnt[2], bus, fails, n_checks;
  int                lens[8] = '{7, 5, 4, 7, 3, 5, 7, 2};
  int                lo[8]   = '{0, 0, 1, 2, 4, 5, 6, 7};
  int                cfgs[21] = '{'h00, 'h20, 'h40, 'h60, 'h80, 'ha0, 'h64, 'h01, 'h29, 'h41,
                                  'h49, 'h2d, 'h35, 'h02, 'h2a, 'h4a, 'h62, 'h82, 'h8a,
                                  'h4e, 'h96};

  lcd_palette_dither_shifter dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_frame_start(i_frame_start), .i_line_start(i_line_start),
    .i_pix_valid(i_pix_valid), .i_pix_data(i_pix_data), .i_pix_half(i_pix_half),
    .o_panel_data_bus(o_panel_data_bus), .o_panel_valid(o_panel_valid),
    .o_panel_half(o_panel_half));
  panel_model pm (.i_mclk(i_mclk), .i_valid(o_panel_valid), .i_half(o_panel_half),
    .i_data(o_panel_data_bus));

  // Core clock, 8 ns
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_mclk) begin i_wr <= 1'b1; i_addr <= a; i_wdata <= d; end
    @(posedge i_mclk) i_wr <= 1'b0;
  endtask : wr

  // Read data stands from the cycle after the strobe until the next read
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    @(posedge i_mclk) begin i_rd <= 1'b1; i_addr <= a; end
    @(posedge i_mclk) i_rd <= 1'b0;
    #1 chk(nm, e, o_rdata);
  endtask : rd

  // Frame rate control decision for one level at sub-pixel count sp
  function automatic int on(input int lv, input int sp);
    int idx, nib, inv;
    if (lv == 15) return 1;
    if (lv == 0) return 0;
    inv = (lv < 8);
    idx = inv ? lo[lv] : 14 - lv;
    nib = (pats[idx] >> (4 * (lens[idx] - 1 - f % lens[idx]))) & 15;
    return ((nib >> (3 - sp % 4)) & 1) ^ inv;
  endfunction : on

  // First bit of a word lands on the top line of its half; other half keeps its lines
  function automatic void push_bit(input int lv, input int hw, input int h, input int dl);
    acc[h] = (acc[h] << 1) | on(lv, s[h]);
    s[h]++;
    cnt[h]++;
    if (cnt[h] == hw) begin
      if (dl) begin
        bus = (bus & ~(((1 << hw) - 1) << (h ? 0 : hw))) | (acc[h] << (h ? 0 : hw));
      end else begin
        bus = acc[h];
      end
      exp_q.push_back({h[0], bus[23:0]});
      acc[h] = 0;
      cnt[h] = 0;
    end
  endfunction : push_bit

  function automatic logic [23:0] tft(input logic [15:0] e);
    return {e[14:10], e[15], 2'b00, e[9:5], e[15], 2'b00, e[4:0], e[15], 2'b00};
  endfunction : tft

  // One frame of one line: eight pixels on random halves, model fed alongside
  task automatic run_line(input int cfg);
    logic [23:0] d;
    logic        hp;
    int          typ, bpp, pal, e, dl, hw, h;
    typ = cfg & 3;
    bpp = (cfg >> 5) & 7;
    pal = (typ == 1) ? (bpp < 2) : (bpp < 4);
    dl  = (typ != 0) && ((cfg >> 2) & 1);
    hw  = ((((cfg >> 3) & 3) == 0) || (dl && ((cfg >> 3) & 3) == 1)) ? 4 : 8;
    @(posedge i_mclk) i_frame_start <= 1'b1;
    @(posedge i_mclk) begin i_frame_start <= 1'b0; i_line_start <= 1'b1; end
    @(posedge i_mclk) i_line_start <= 1'b0;
    f++;
    s   = '{0, 0};
    acc = '{0, 0};
    cnt = '{0, 0};
    for (int i = 0; i < 8; i++) begin
      d  = $urandom;
      hp = d[23];
      h  = dl ? hp : 0;
      if (pal) d = d & ((1 << (1 << bpp)) - 1);
      else if (typ == 1) d = d & 24'h00000f;
      else if (bpp != 5) d = d & 24'h00ffff;
      e = pal ? lut[d[7:0]] : d[15:0];
      if (typ == 0) begin
        bus = (bpp == 5) ? d : tft(e[15:0]);
        exp_q.push_back({1'b0, bus[23:0]});
      end else if (typ == 1) begin
        push_bit(pal ? e[4:1] : d[3:0], hw, h, dl);
      end else begin
        for (int c = 0; c < 3; c++) push_bit(e[5*c+1 +: 4], hw, h, dl);
      end
      i_pix_valid <= 1'b1;
      i_pix_data <= d;
      i_pix_half <= hp;
      @(posedge i_mclk);
    end
    i_pix_valid <= 1'b0;
  endtask : run_line

  // Bounded wait for the words, then compare in order
  task automatic drain();
    int k;
    for (k = 0; k < 40 && pm.got.size() < exp_q.size(); k++) @(posedge i_mclk);
    if (k == 40) begin
      fails++;
      tally_and_finish();
    end
    repeat (3) @(posedge i_mclk);
    chk("word count", exp_q.size(), pm.got.size());
    while (exp_q.size() > 0 && pm.got.size() > 0)
      chk("panel word", exp_q.pop_front(), pm.got.pop_front());
    exp_q.delete();
    pm.got.delete();
  endtask : drain

  // Main sequence
  initial begin
    logic [31:0] d32;
    {i_rstn, i_wr, i_rd, i_frame_start, i_line_start, i_pix_valid, i_pix_half} = '0;
    i_addr = '0;
    i_wdata = '0;
    i_pix_data = '0;
    void'($urandom(58));
    repeat (10) @(posedge i_mclk);
    i_rstn <= 1'b1;
    rd(CFG_OFF, 32'h0, "config reset");
    for (int i = 0; i < 256; i++) begin
      d32 = $urandom;
      lut[i] = d32[15:0];
      wr(LUT_BASE + 12'(4 * i), d32);
    end
    for (int i = 0; i < 256; i++) rd(LUT_BASE + 12'(4 * i), lut[i], "palette");
    rd(12'h100, 32'h0, "unmapped");
    rd(LUT_BASE + 12'h002, 32'h0, "unaligned");
    for (int i = 0; i < 8; i++) begin
      d32 = $urandom;
      pats[i] = d32[27:0];
      wr(PAT_BASE + 12'(4 * i), d32);
      rd(PAT_BASE + 12'(4 * i), pats[i], "pattern");
    end
    foreach (cfgs[j]) begin
      wr(CFG_OFF, cfgs[j]);
      rd(CFG_OFF, cfgs[j], "config");
      repeat (8) begin
        run_line(cfgs[j]);
        drain();
      end
    end
    d32 = '0;
    for (int i = 0; i < 8; i++) d32 = d32 | 32'((f % lens[i]) << (3 * i));
    rd(STAT_OFF, d32, "phase status");
    tally_and_finish();
  end

  // Watchdog against a hang
  initial begin
    #400000;
    fails++;
    tally_and_finish();
  end
endmodule : lcd_palette_dither_shifter_bench
`default_nettype wire
